// *** pkg/sdcap_pkg.sv ***
`default_nettype none
package sdcap_pkg;
  // Pin field widths, bank count and auto-precharge bit position
  localparam int SDCAP_ADDR_W = 13;
  localparam int SDCAP_COL_W = 9;
  localparam int SDCAP_BANKS = 4;
  localparam int SDCAP_BANK_W = 2;
  localparam int SDCAP_AP_BIT = 10;

  // Mode register choice on the bank select pair
  localparam logic [1:0] SDCAP_MODE_STD_SEL = 2'h0;
  localparam logic [1:0] SDCAP_MODE_EXT_SEL = 2'h2;

  // Values after reset
  localparam logic SDCAP_CLK_EN_RST = 1'h1;
  localparam logic SDCAP_SEL_N_RST = 1'h1;
  localparam logic [12:0] SDCAP_ADDR_RST = 13'h0000;
  localparam logic [1:0] SDCAP_BANK_RST = 2'h0;
  localparam logic [12:0] SDCAP_MODE_RST = 13'h0000;
  localparam logic [7:0] SDCAP_BURST_CNT_RST = 8'h00;

  // Commands, coded as {row, col, write} strobes, active low
  typedef enum logic [2:0] {
    SDCAP_CMD_MODE = 3'b000,
    SDCAP_CMD_REFRESH = 3'b001,
    SDCAP_CMD_PRECHARGE = 3'b010,
    SDCAP_CMD_ACTIVATE = 3'b011,
    SDCAP_CMD_WRITE = 3'b100,
    SDCAP_CMD_READ = 3'b101,
    SDCAP_CMD_TERMINATE = 3'b110,
    SDCAP_CMD_NOP = 3'b111
  } sdcap_cmd_t;
endpackage
`default_nettype wire

// *** pkg/sdcap_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface sdcap_if;
  import sdcap_pkg::*;
  logic clk_en;
  logic dev_sel_n;
  logic row_strobe_n;
  logic col_strobe_n;
  logic write_strobe_n;
  logic bank_select_low;
  logic bank_select_high;
  logic [SDCAP_ADDR_W-1:0] addr;

  // Memory controller end
  modport ctrl (
    output clk_en, dev_sel_n, row_strobe_n, col_strobe_n, write_strobe_n,
    output bank_select_low, bank_select_high, addr
  );

  // Memory device end
  modport dev (
    input clk_en, dev_sel_n, row_strobe_n, col_strobe_n, write_strobe_n,
    input bank_select_low, bank_select_high, addr
  );
endinterface
`default_nettype wire

// *** rtl/sdcap_ctrl_end.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdcap_ctrl_end
  import sdcap_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Pins toward the device
  sdcap_if.ctrl pins,
  // User command side
  input wire logic user_clk_en,
  input wire logic user_cmd_valid,
  input wire sdcap_cmd_t user_cmd,
  input wire logic [SDCAP_BANK_W-1:0] user_bank,
  input wire logic [SDCAP_ADDR_W-1:0] user_addr,
  input wire logic user_auto_precharge,
  output logic user_cmd_taken_q
);
  logic clk_en_q;
  logic sel_n_q;
  logic [2:0] strobes_q;
  logic [SDCAP_BANK_W-1:0] bank_q;
  logic [SDCAP_ADDR_W-1:0] addr_q;
  logic [SDCAP_ADDR_W-1:0] addr_d;
  logic take;

  // Commands only go out while the clock gate is on
  assign take = user_cmd_valid && user_clk_en;

  // Address field per command
  always_comb begin
    addr_d = user_addr;
    unique case (user_cmd)
      SDCAP_CMD_READ, SDCAP_CMD_WRITE, SDCAP_CMD_PRECHARGE: begin
        addr_d[SDCAP_AP_BIT] = user_auto_precharge;
      end
      default: begin
        addr_d = user_addr;
      end
    endcase
  end

  // Clock gate pin
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      clk_en_q <= SDCAP_CLK_EN_RST;
    end else begin
      clk_en_q <= user_clk_en;
    end
  end

  // Select and strobes, one cycle per command
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sel_n_q <= SDCAP_SEL_N_RST;
      strobes_q <= SDCAP_CMD_NOP;
      user_cmd_taken_q <= 1'b0;
    end else begin
      sel_n_q <= !take;
      strobes_q <= take ? user_cmd : SDCAP_CMD_NOP;
      user_cmd_taken_q <= take;
    end
  end

  // Bank and address
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bank_q <= SDCAP_BANK_RST;
      addr_q <= SDCAP_ADDR_RST;
    end else if (take) begin
      bank_q <= user_bank;
      addr_q <= addr_d;
    end
  end

  assign pins.clk_en = clk_en_q;
  assign pins.dev_sel_n = sel_n_q;
  assign pins.row_strobe_n = strobes_q[2];
  assign pins.col_strobe_n = strobes_q[1];
  assign pins.write_strobe_n = strobes_q[0];
  assign pins.bank_select_low = bank_q[0];
  assign pins.bank_select_high = bank_q[1];
  assign pins.addr = addr_q;
endmodule // sdcap_ctrl_end
`default_nettype wire

// *** rtl/sdcap_dev_end.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdcap_dev_end
  import sdcap_pkg::*;
#(
  parameter int BURST_LEN = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Pins from the controller
  sdcap_if.dev pins,
  // Decoded command view
  output sdcap_cmd_t last_cmd_q,
  output logic cmd_pulse_q,
  output logic [SDCAP_BANK_W-1:0] last_bank_q,
  // Bank state
  output logic [SDCAP_BANKS-1:0] bank_open_q,
  output logic [SDCAP_BANKS*SDCAP_ADDR_W-1:0] bank_row_q,
  output logic [SDCAP_BANKS-1:0] precharge_pulse_q,
  // Burst state
  output logic burst_active_q,
  output logic burst_write_q,
  output logic [SDCAP_BANK_W-1:0] burst_bank_q,
  output logic [SDCAP_COL_W-1:0] col_addr_q,
  output logic burst_auto_pre_q,
  // Mode registers and power
  output logic [SDCAP_ADDR_W-1:0] mode_reg_q,
  output logic [SDCAP_ADDR_W-1:0] ext_mode_reg_q,
  output logic refresh_pulse_q,
  output logic suspended_q
);
  // Refuse burst lengths below 1 or above 255
  if (BURST_LEN < 1 || BURST_LEN > 255) begin : g_bad_len
    $error("BURST_LEN must be 1 to 255");
  end

  // Counter value on the last beat
  localparam logic [7:0] BURST_LAST = 8'(BURST_LEN - 1);

  // Sampled pins
  logic clk_en_q;
  logic sel_n_q;
  logic [2:0] strobes_q;
  logic [SDCAP_BANK_W-1:0] bank_in_q;
  logic [SDCAP_ADDR_W-1:0] addr_in_q;
  // Internal
  logic run;
  sdcap_cmd_t cmd;
  logic [7:0] burst_cnt_q;
  logic burst_end;
  logic ap_in;
  logic [SDCAP_BANKS-1:0] pre_d;

  // Input register on the rising edge
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      clk_en_q <= SDCAP_CLK_EN_RST;
      sel_n_q <= SDCAP_SEL_N_RST;
      strobes_q <= SDCAP_CMD_NOP;
      bank_in_q <= SDCAP_BANK_RST;
      addr_in_q <= SDCAP_ADDR_RST;
    end else begin
      clk_en_q <= pins.clk_en;
      sel_n_q <= pins.dev_sel_n;
      strobes_q <= {pins.row_strobe_n, pins.col_strobe_n, pins.write_strobe_n};
      bank_in_q <= {pins.bank_select_high, pins.bank_select_low};
      addr_in_q <= pins.addr;
    end
  end

  // Internal clock runs only while the gate was high
  assign run = clk_en_q;

  // Command decode, select gates the decoder
  always_comb begin
    cmd = SDCAP_CMD_NOP;
    if (run && !sel_n_q) begin
      cmd = sdcap_cmd_t'(strobes_q);
    end
  end

  // Auto-precharge bit, and last beat, which is held off while the gate is low
  assign ap_in = addr_in_q[SDCAP_AP_BIT];
  assign burst_end = burst_active_q && run && (burst_cnt_q == BURST_LAST);

  // Power state seen by the array
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      suspended_q <= 1'b0;
    end else begin
      suspended_q <= !run;
    end
  end

  // Decoded command record
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      last_cmd_q <= SDCAP_CMD_NOP;
      cmd_pulse_q <= 1'b0;
      last_bank_q <= SDCAP_BANK_RST;
      refresh_pulse_q <= 1'b0;
    end else begin
      cmd_pulse_q <= (cmd != SDCAP_CMD_NOP);
      refresh_pulse_q <= (cmd == SDCAP_CMD_REFRESH);
      if (cmd != SDCAP_CMD_NOP) begin
        last_cmd_q <= cmd;
        last_bank_q <= bank_in_q;
      end
    end
  end

  // Mode registers picked by the bank pair
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mode_reg_q <= SDCAP_MODE_RST;
      ext_mode_reg_q <= SDCAP_MODE_RST;
    end else if (cmd == SDCAP_CMD_MODE) begin
      if (bank_in_q == SDCAP_MODE_STD_SEL) begin
        mode_reg_q <= addr_in_q;
      end
      if (bank_in_q == SDCAP_MODE_EXT_SEL) begin
        ext_mode_reg_q <= addr_in_q;
      end
    end
  end

  // Burst engine keeps going while deselected
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      burst_active_q <= 1'b0;
      burst_write_q <= 1'b0;
      burst_bank_q <= SDCAP_BANK_RST;
      col_addr_q <= '0;
      burst_auto_pre_q <= 1'b0;
      burst_cnt_q <= SDCAP_BURST_CNT_RST;
    end else if (cmd == SDCAP_CMD_READ || cmd == SDCAP_CMD_WRITE) begin
      burst_active_q <= 1'b1;
      burst_write_q <= (cmd == SDCAP_CMD_WRITE);
      burst_bank_q <= bank_in_q;
      col_addr_q <= addr_in_q[SDCAP_COL_W-1:0];
      burst_auto_pre_q <= ap_in;
      burst_cnt_q <= SDCAP_BURST_CNT_RST;
    end else if (cmd == SDCAP_CMD_TERMINATE) begin
      burst_active_q <= 1'b0;
      burst_auto_pre_q <= 1'b0;
    end else if (burst_end) begin
      burst_active_q <= 1'b0;
      burst_auto_pre_q <= 1'b0;
    end else if (burst_active_q && run) begin
      burst_cnt_q <= burst_cnt_q + 8'h01;
    end
  end

  // Banks to close this cycle
  always_comb begin
    pre_d = '0;
    if (burst_end && burst_auto_pre_q) begin
      pre_d[burst_bank_q] = 1'b1;
    end
    if (cmd == SDCAP_CMD_PRECHARGE) begin
      if (ap_in) begin
        pre_d = '1;
      end else begin
        pre_d[bank_in_q] = 1'b1;
      end
    end
  end

  // Per-bank row state
  genvar b;
  generate
    for (b = 0; b < SDCAP_BANKS; b++) begin : g_bank
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          bank_open_q[b] <= 1'b0;
          bank_row_q[b*SDCAP_ADDR_W +: SDCAP_ADDR_W] <= SDCAP_ADDR_RST;
          precharge_pulse_q[b] <= 1'b0;
        end else begin
          precharge_pulse_q[b] <= pre_d[b];
          // Activate wins over a precharge landing in the same cycle
          if (cmd == SDCAP_CMD_ACTIVATE && bank_in_q == SDCAP_BANK_W'(b)) begin
            bank_open_q[b] <= 1'b1;
            bank_row_q[b*SDCAP_ADDR_W +: SDCAP_ADDR_W] <= addr_in_q;
          end else if (pre_d[b]) begin
            bank_open_q[b] <= 1'b0;
          end
        end
      end
    end
  endgenerate
endmodule // sdcap_dev_end
`default_nettype wire

// *** tb/sdcap_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdcap_chk
  import sdcap_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Pins between the two ends
  input wire logic clk_en,
  input wire logic dev_sel_n,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic write_strobe_n,
  input wire logic bank_select_low,
  input wire logic bank_select_high,
  input wire logic [SDCAP_ADDR_W-1:0] addr,
  // Device state watched
  input wire logic [SDCAP_BANKS-1:0] bank_open,
  input wire logic suspended
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Strobes as one command code
  wire logic [2:0] cmd = {row_strobe_n, col_strobe_n, write_strobe_n};
  wire logic [1:0] bank = {bank_select_high, bank_select_low};

  // Deselected cycles carry only no-operation
  idle_nop_a: assert property (dev_sel_n |-> cmd == 3'h7)
    else $error("strobes active while deselected");
  // A command only goes out with the clock running
  run_cmd_a: assert property (!dev_sel_n |-> clk_en)
    else $error("command sent with clock gate low");
  // Deselected cycles keep bank and address still
  desel_hold_a: assert property (dev_sel_n |-> $stable(addr) && $stable(bank))
    else $error("bank or address moved while deselected");
  // Activate opens the addressed bank two edges on
  act_open_a: assert property (
    !dev_sel_n && cmd == SDCAP_CMD_ACTIVATE |-> ##2 bank_open[$past(bank, 2)])
    else $error("activated bank not open");
  // Precharge with the flag high closes every bank
  pre_all_a: assert property (
    !dev_sel_n && cmd == SDCAP_CMD_PRECHARGE && addr[SDCAP_AP_BIT] |-> ##2 bank_open == '0)
    else $error("banks left open after precharge all");
  // Precharge with the flag low closes the addressed bank
  pre_one_a: assert property (
    !dev_sel_n && cmd == SDCAP_CMD_PRECHARGE && !addr[SDCAP_AP_BIT]
    |-> ##2 !bank_open[$past(bank, 2)])
    else $error("addressed bank left open after precharge");
  // Gate low stops the device two edges on
  gate_susp_a: assert property (!clk_en |-> ##2 suspended)
    else $error("device not suspended with gate low");

  // Main scenarios
  act_c: cover property (!dev_sel_n && cmd == SDCAP_CMD_ACTIVATE);
  pre_all_c: cover property (!dev_sel_n && cmd == SDCAP_CMD_PRECHARGE && addr[10]);
  ext_c: cover property (!dev_sel_n && cmd == SDCAP_CMD_MODE && bank == SDCAP_MODE_EXT_SEL);
endmodule // sdcap_chk
`default_nettype wire

// *** tb/sdram_command_address_port_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdram_command_address_port_tb_top;
  import sdcap_pkg::*;
  // User side stimulus
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic u_en = 1'b1;
  logic u_vld = 1'b0;
  logic u_ap = 1'b0;
  sdcap_cmd_t u_cmd = SDCAP_CMD_NOP;
  logic [1:0] u_bank = 2'h0;
  logic [12:0] u_addr = 13'h0000;
  // Observed outputs
  logic taken;
  logic burst;
  logic susp;
  logic [3:0] open_q;
  logic [51:0] rows;
  logic [8:0] col;
  logic [12:0] mreg;
  logic [12:0] xreg;
  sdcap_cmd_t last;
  logic ref_p;
  logic cmd_p;
  logic bwr;
  logic bap;
  logic [1:0] lbank;
  logic [1:0] bbank;
  logic [3:0] pre_p;
  int n_ref = 0;
  int n_pre = 0;
  int n_cmd = 0;
  int fails = 0;
  int tests_run = 0;

  // Both ends joined by the pins
  sdcap_if i_sdcap_if ();
  sdcap_ctrl_end i_sdcap_ctrl_end (.sys_clk(sys_clk), .resetn(resetn), .pins(i_sdcap_if),
    .user_clk_en(u_en), .user_cmd_valid(u_vld), .user_cmd(u_cmd), .user_bank(u_bank),
    .user_addr(u_addr), .user_auto_precharge(u_ap), .user_cmd_taken_q(taken));
  sdcap_dev_end #(.BURST_LEN(4)) i_sdcap_dev_end (.sys_clk(sys_clk), .resetn(resetn),
    .pins(i_sdcap_if), .last_cmd_q(last), .cmd_pulse_q(cmd_p), .last_bank_q(lbank),
    .bank_open_q(open_q), .bank_row_q(rows), .precharge_pulse_q(pre_p), .burst_active_q(burst),
    .burst_write_q(bwr), .burst_bank_q(bbank), .col_addr_q(col), .burst_auto_pre_q(bap),
    .mode_reg_q(mreg), .ext_mode_reg_q(xreg), .refresh_pulse_q(ref_p), .suspended_q(susp));
  sdcap_chk i_sdcap_chk (.sys_clk(sys_clk), .resetn(resetn), .clk_en(i_sdcap_if.clk_en),
    .dev_sel_n(i_sdcap_if.dev_sel_n), .row_strobe_n(i_sdcap_if.row_strobe_n),
    .col_strobe_n(i_sdcap_if.col_strobe_n), .write_strobe_n(i_sdcap_if.write_strobe_n),
    .bank_select_low(i_sdcap_if.bank_select_low),
    .bank_select_high(i_sdcap_if.bank_select_high), .addr(i_sdcap_if.addr),
    .bank_open(open_q), .suspended(susp));

  // Clock
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  // Pulse counters, taken on the rising edge
  always @(posedge sys_clk) begin
    if (resetn) begin
      n_ref <= n_ref + int'(ref_p);
      n_cmd <= n_cmd + int'(cmd_p);
      n_pre <= n_pre + $countones(pre_p);
    end
  end

  // Compare and count
  task automatic chk(input logic [51:0] got, input logic [51:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // One request held over one rising edge, valid left high
  task automatic send(input sdcap_cmd_t c, input logic [1:0] b, input logic [12:0] a,
                      input logic p);
    u_cmd = c;
    u_bank = b;
    u_addr = a;
    u_ap = p;
    u_vld = 1'b1;
    cyc(1);
  endtask

  // One request, then let it reach the device state
  task automatic issue(input sdcap_cmd_t c, input logic [1:0] b, input logic [12:0] a,
                       input logic p, input logic exp_taken);
    send(c, b, a, p);
    u_vld = 1'b0;
    chk(taken, exp_taken, "taken pulse");
    cyc(3);
  endtask

  task automatic t_act;
    issue(SDCAP_CMD_ACTIVATE, 2'h1, 13'h1ABC, 1'b0, 1'b1);
    chk(open_q, 4'h2, "bank open");
    chk(rows[25:13], 13'h1ABC, "row");
    chk(last, SDCAP_CMD_ACTIVATE, "activate code");
    chk(lbank, 2'h1, "last bank");
    chk(n_cmd, 1, "one decode");
    $display("t_act done");
  endtask

  task automatic t_mode;
    issue(SDCAP_CMD_MODE, SDCAP_MODE_STD_SEL, 13'h0123, 1'b0, 1'b1);
    issue(SDCAP_CMD_MODE, SDCAP_MODE_EXT_SEL, 13'h1F00, 1'b0, 1'b1);
    issue(SDCAP_CMD_MODE, 2'h1, 13'h0555, 1'b0, 1'b1);
    chk(mreg, 13'h0123, "mode reg");
    chk(xreg, 13'h1F00, "ext mode reg");
    $display("t_mode done");
  endtask

  task automatic t_read;
    issue(SDCAP_CMD_READ, 2'h1, 13'h1BFF, 1'b1, 1'b1);
    chk(burst, 1'b1, "burst start");
    chk(col, 9'h1FF, "column");
    chk({bwr, bbank, bap}, 4'h3, "read burst fields");
    cyc(8);
    chk(burst, 1'b0, "burst end");
    chk(open_q, 4'h0, "auto close");
    chk(n_pre, 1, "auto precharge pulse");
    $display("t_read done");
  endtask

  task automatic t_pre;
    issue(SDCAP_CMD_ACTIVATE, 2'h0, 13'h0011, 1'b0, 1'b1);
    issue(SDCAP_CMD_ACTIVATE, 2'h2, 13'h0022, 1'b0, 1'b1);
    issue(SDCAP_CMD_ACTIVATE, 2'h3, 13'h0033, 1'b0, 1'b1);
    issue(SDCAP_CMD_PRECHARGE, 2'h2, 13'h0000, 1'b0, 1'b1);
    chk(open_q, 4'h9, "single close");
    chk(n_pre, 2, "single pulse");
    issue(SDCAP_CMD_PRECHARGE, 2'h1, 13'h0000, 1'b1, 1'b1);
    chk(open_q, 4'h0, "all close");
    chk(n_pre, 6, "all pulses");
    $display("t_pre done");
  endtask

  task automatic t_gate;
    u_en = 1'b0;
    cyc(3);
    chk(susp, 1'b1, "suspended");
    issue(SDCAP_CMD_ACTIVATE, 2'h0, 13'h0044, 1'b0, 1'b0);
    chk(open_q, 4'h0, "gated ignored");
    chk(n_cmd, 10, "gated no decode");
    u_en = 1'b1;
    cyc(3);
    chk(susp, 1'b0, "resumed");
    $display("t_gate done");
  endtask

  task automatic t_misc;
    issue(SDCAP_CMD_REFRESH, 2'h0, 13'h0000, 1'b0, 1'b1);
    chk(last, SDCAP_CMD_REFRESH, "refresh code");
    chk(n_ref, 1, "refresh pulse");
    issue(SDCAP_CMD_WRITE, 2'h3, 13'h0005, 1'b0, 1'b1);
    chk(burst, 1'b1, "burst runs deselected");
    chk({bwr, bbank}, 3'h7, "write burst bank");
    send(SDCAP_CMD_WRITE, 2'h3, 13'h0006, 1'b0);
    send(SDCAP_CMD_TERMINATE, 2'h0, 13'h0000, 1'b0);
    u_vld = 1'b0;
    cyc(2);
    chk(burst, 1'b0, "terminated");
    $display("t_misc done");
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog
  initial begin
    #4000;
    fails++;
    print_verdict();
  end

  // Main sequence
  initial begin
    cyc(20);
    resetn = 1'b1;
    cyc(1);
    t_act();
    t_mode();
    t_read();
    t_pre();
    t_gate();
    t_misc();
    print_verdict();
  end
endmodule // sdram_command_address_port_tb_top
`default_nettype wire
